/* issu_unit.sv */
module issu_unit
    import issu_pkg::*;
#(
    parameter int unsigned SUPERSCALAR = 1
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Issue request
    input wire logic VALID_I,
    input wire logic [INSN_W-1:0] INSN_I,
    input wire logic [WORD_W-1:0] OPERAND_A_I,
    input wire logic [WORD_W-1:0] OPERAND_B_I,
    // Result
    output logic DONE_O,
    output logic WRITE_EN_O,
    output logic [IDX_W-1:0] DEST_INDEX_O,
    output logic [WORD_W-1:0] RESULT_O,
    output logic OVERFLOW_O,
    output logic ILLEGAL_O,
    // Issue control
    output logic ISSUE_BREAK_O,
    output logic ISSUE_ALONE_O
);
    typedef enum logic [2:0] {
        ISSU_NONE, ISSU_ASHR_VAR, ISSU_ZSHR_IMM, ISSU_ZSHR_VAR, ISSU_SHL_IMM, ISSU_SUB_T, ISSU_SUB_W
    } issu_op_t;

    // Zero-fill or sign-fill right shift shared by three instructions
    function automatic logic [WORD_W-1:0] right_shift(input logic [WORD_W-1:0] val,
            input logic [IDX_W-1:0] cnt, input logic fill);
        logic [2*WORD_W-1:0] wide;
        wide = {{WORD_W{fill}}, val} >> cnt;
        return wide[WORD_W-1:0];
    endfunction

    wire logic [5:0] opcode = INSN_I[OPC_MSB:OPC_LSB];
    wire logic [IDX_W-1:0] operand_a_index = INSN_I[OPA_MSB:OPA_LSB];
    wire logic [IDX_W-1:0] operand_b_index = INSN_I[OPB_MSB:OPB_LSB];
    wire logic [IDX_W-1:0] dest_index = INSN_I[DST_MSB:DST_LSB];
    wire logic [IDX_W-1:0] shift_amount_field = INSN_I[SHAMT_MSB:SHAMT_LSB];
    wire logic [5:0] func = INSN_I[FUNC_MSB:FUNC_LSB];
    wire logic special = (opcode == OPC_SPECIAL);
    wire logic shamt_zero = (shift_amount_field == 5'h00);
    wire logic [IDX_W-1:0] var_count = OPERAND_A_I[IDX_W-1:0];

    wire logic is_issue_break = special && func == FN_IMM_LEFT_SHIFT && dest_index == 5'h00
        && operand_b_index == 5'h00 && shift_amount_field == ISSUE_BREAK_SHAMT;

    issu_op_t op;
    always_comb begin
        op = ISSU_NONE;
        if (special) begin
            unique case (func)
                FN_VAR_ARITH_RIGHT_SHIFT: op = shamt_zero ? ISSU_ASHR_VAR : ISSU_NONE;
                FN_IMM_LOGIC_RIGHT_SHIFT: op = ISSU_ZSHR_IMM;
                FN_VAR_LOGIC_RIGHT_SHIFT: op = ISSU_ZSHR_VAR;
                FN_IMM_LEFT_SHIFT: op = ISSU_SHL_IMM;
                FN_TRAPPING_SUB: op = shamt_zero ? ISSU_SUB_T : ISSU_NONE;
                FN_WRAPPING_DIFFERENCE: op = shamt_zero ? ISSU_SUB_W : ISSU_NONE;
                default: op = ISSU_NONE;
            endcase
        end
    end

    // 33-bit sign-extended difference exposes overflow as bit 32 differing from bit 31
    wire logic [WORD_W:0] diff33 = {OPERAND_A_I[SIGN_BIT], OPERAND_A_I}
        - {OPERAND_B_I[SIGN_BIT], OPERAND_B_I};
    wire logic sub_ovf = diff33[WORD_W] != diff33[WORD_W-1];

    logic [WORD_W-1:0] next_result;
    logic next_write_en;
    logic next_overflow;
    always_comb begin
        next_result = RESULT_RST;
        next_write_en = 1'b1;
        next_overflow = 1'b0;
        unique case (op)
            ISSU_ASHR_VAR: next_result = right_shift(OPERAND_B_I, var_count, OPERAND_B_I[SIGN_BIT]);
            ISSU_ZSHR_IMM: next_result = right_shift(OPERAND_B_I, shift_amount_field, 1'b0);
            ISSU_ZSHR_VAR: next_result = right_shift(OPERAND_B_I, var_count, 1'b0);
            ISSU_SHL_IMM: begin
                next_result = OPERAND_B_I << shift_amount_field;
                // Issue-break leaves state untouched; a plain no-op still raises the write strobe
                next_write_en = !is_issue_break;
            end
            ISSU_SUB_T: begin
                next_result = diff33[WORD_W-1:0];
                next_write_en = !sub_ovf;
                next_overflow = sub_ovf;
            end
            ISSU_SUB_W: next_result = diff33[WORD_W-1:0];
            ISSU_NONE: next_write_en = 1'b0;
        endcase
    end

    wire logic accept = VALID_I;
    wire logic known = (op != ISSU_NONE);

    // One completion pulse per accepted instruction, one issue slot each
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            DONE_O <= 1'b0;
        end else begin
            DONE_O <= accept;
        end
    end

    // Write strobe drops on overflow so the destination keeps its value
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            WRITE_EN_O <= 1'b0;
        end else begin
            WRITE_EN_O <= accept && next_write_en;
        end
    end

    // Destination index always follows the instruction
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            DEST_INDEX_O <= DEST_RST;
        end else begin
            DEST_INDEX_O <= dest_index;
        end
    end

    // Result is loaded even when unused; saves a mux on the wide path
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RESULT_O <= RESULT_RST;
        end else begin
            RESULT_O <= next_result;
        end
    end

    // Only the trapping subtract can raise an overflow
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            OVERFLOW_O <= 1'b0;
        end else begin
            OVERFLOW_O <= accept && next_overflow;
        end
    end

    // Unknown encodings are reported, never executed
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ILLEGAL_O <= 1'b0;
        end else begin
            ILLEGAL_O <= accept && !known;
        end
    end

    // Break is a one-cycle hint; no stall, so no extra delay
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ISSUE_BREAK_O <= 1'b0;
        end else begin
            ISSUE_BREAK_O <= accept && is_issue_break;
        end
    end

    // Issue logic ends the group only on a superscalar core
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ISSUE_ALONE_O <= 1'b0;
        end else begin
            ISSUE_ALONE_O <= accept && is_issue_break && (SUPERSCALAR != 0);
        end
    end

    a_overflow_no_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        OVERFLOW_O |-> !WRITE_EN_O && DONE_O)
        else $error("overflow with write");
    a_sub_trap_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_SUB_T && sub_ovf |=> OVERFLOW_O)
        else $error("missed overflow");
    a_wrap_no_trap: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_SUB_W |=> !OVERFLOW_O && WRITE_EN_O
        && RESULT_O == $past(OPERAND_A_I) - $past(OPERAND_B_I))
        else $error("wrapping difference wrong");
    a_sra_fill: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ASHR_VAR && OPERAND_B_I[31] && OPERAND_A_I[4:0] != 5'h00
        |=> RESULT_O[31])
        else $error("sign not copied");
    a_var_count_low: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ZSHR_VAR |=> RESULT_O == ($past(OPERAND_B_I) >> $past(OPERAND_A_I[4:0])))
        else $error("count bits wrong");
    a_srl_imm_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ZSHR_IMM && INSN_I[10:6] != 5'h00 |=> !RESULT_O[31])
        else $error("fill not zero");
    a_srl_var_value: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ZSHR_VAR && OPERAND_A_I[4:0] == 5'h1f |=> RESULT_O[31:1] == 31'h0)
        else $error("variable shift wrong");
    a_break_no_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        ISSUE_BREAK_O |-> !WRITE_EN_O && DONE_O && !OVERFLOW_O)
        else $error("issue-break wrote state");
    a_break_alone: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && is_issue_break |=> ISSUE_ALONE_O == (SUPERSCALAR != 0) ##1 !ISSUE_BREAK_O || $past(VALID_I))
        else $error("issue-break not alone");
    a_sub_shamt: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && special && func == FN_TRAPPING_SUB && !shamt_zero |=> ILLEGAL_O && !WRITE_EN_O)
        else $error("bad trapping encoding accepted");

    // Slot accounting
    a_done_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I |=> DONE_O)
        else $error("accepted instruction not completed");
    a_done_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
        !VALID_I |=> !DONE_O)
        else $error("completion without instruction");
    a_idle_quiet: assert property (@(posedge CLK_I) disable iff (RST_I)
        !VALID_I |=> !WRITE_EN_O && !OVERFLOW_O && !ILLEGAL_O && !ISSUE_BREAK_O)
        else $error("idle cycle raised a pulse");
    a_write_done: assert property (@(posedge CLK_I) disable iff (RST_I)
        WRITE_EN_O |-> DONE_O)
        else $error("write without completion");
    a_illegal_done: assert property (@(posedge CLK_I) disable iff (RST_I)
        ILLEGAL_O |-> DONE_O)
        else $error("illegal without completion");
    a_dest_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I |=> DEST_INDEX_O == $past(INSN_I[15:11]))
        else $error("destination index wrong");
    a_opcode_illegal: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && !special |=> ILLEGAL_O && !WRITE_EN_O)
        else $error("foreign opcode executed");

    // Issue-break
    a_break_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && is_issue_break |=> ISSUE_BREAK_O)
        else $error("issue-break missed");
    a_break_only: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && !is_issue_break |=> !ISSUE_BREAK_O)
        else $error("false issue-break");
    a_break_legal: assert property (@(posedge CLK_I) disable iff (RST_I)
        ISSUE_BREAK_O |-> !ILLEGAL_O)
        else $error("issue-break flagged illegal");
    a_alone_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
        ISSUE_ALONE_O |-> ISSUE_BREAK_O)
        else $error("issue-alone without break");
    a_alone_mode: assert property (@(posedge CLK_I) disable iff (RST_I)
        ISSUE_BREAK_O |-> ISSUE_ALONE_O == (SUPERSCALAR != 0))
        else $error("issue-alone wrong for core width");
    a_break_no_delay: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && is_issue_break ##1 VALID_I |=> DONE_O)
        else $error("instruction after break delayed");

    // Shifts
    a_sra_zero_count: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ASHR_VAR && OPERAND_A_I[4:0] == 5'h00 |=> RESULT_O == $past(OPERAND_B_I))
        else $error("zero count changed value");
    a_sra_full_count: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ASHR_VAR && OPERAND_A_I[4:0] == 5'h1f |=> RESULT_O == {32{$past(OPERAND_B_I[31])}})
        else $error("full shift not sign fill");
    a_sra_shamt: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && special && func == FN_VAR_ARITH_RIGHT_SHIFT && !shamt_zero |=> ILLEGAL_O)
        else $error("bad arithmetic shift accepted");
    a_srl_imm_value: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ZSHR_IMM |=> RESULT_O == ($past(OPERAND_B_I) >> $past(INSN_I[10:6])))
        else $error("immediate shift wrong");
    a_srl_var_fill: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ZSHR_VAR && OPERAND_A_I[4:0] != 5'h00 |=> !RESULT_O[31])
        else $error("variable shift fill not zero");
    a_count_high: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_ZSHR_VAR && OPERAND_A_I[31:5] != 27'h0
        |=> RESULT_O == ($past(OPERAND_B_I) >> $past(OPERAND_A_I[4:0])))
        else $error("high count bits used");
    a_shift_writes: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && (op == ISSU_ASHR_VAR || op == ISSU_ZSHR_IMM || op == ISSU_ZSHR_VAR)
        |=> WRITE_EN_O && !ILLEGAL_O && !OVERFLOW_O)
        else $error("shift trapped or skipped");

    // Subtraction
    a_sub_clean: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op == ISSU_SUB_T && !sub_ovf
        |=> WRITE_EN_O && !OVERFLOW_O && RESULT_O == $past(OPERAND_A_I) - $past(OPERAND_B_I))
        else $error("clean subtract not written");
    a_ovf_source: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && op != ISSU_SUB_T |=> !OVERFLOW_O)
        else $error("overflow from wrong instruction");
    a_sub_legal: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && special && func == FN_TRAPPING_SUB && shamt_zero |=> !ILLEGAL_O)
        else $error("legal trapping subtract refused");
    a_wrap_shamt: assert property (@(posedge CLK_I) disable iff (RST_I)
        VALID_I && special && func == FN_WRAPPING_DIFFERENCE && !shamt_zero |=> ILLEGAL_O && !WRITE_EN_O)
        else $error("bad wrapping encoding accepted");
    a_illegal_quiet: assert property (@(posedge CLK_I) disable iff (RST_I)
        ILLEGAL_O |-> !WRITE_EN_O && !OVERFLOW_O)
        else $error("illegal instruction had effect");
endmodule

/* issu_pkg.sv */
package issu_pkg;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned INSN_W = 32;
    // Instruction field positions
    localparam int unsigned OPC_MSB = 31;
    localparam int unsigned OPC_LSB = 26;
    localparam int unsigned OPA_MSB = 25;
    localparam int unsigned OPA_LSB = 21;
    localparam int unsigned OPB_MSB = 20;
    localparam int unsigned OPB_LSB = 16;
    localparam int unsigned DST_MSB = 15;
    localparam int unsigned DST_LSB = 11;
    localparam int unsigned SHAMT_MSB = 10;
    localparam int unsigned SHAMT_LSB = 6;
    localparam int unsigned FUNC_MSB = 5;
    localparam int unsigned FUNC_LSB = 0;
    localparam int unsigned SIGN_BIT = 31;
    // Encodings
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] FN_IMM_LEFT_SHIFT = 6'h00;
    localparam logic [5:0] FN_IMM_LOGIC_RIGHT_SHIFT = 6'h02;
    localparam logic [5:0] FN_VAR_LOGIC_RIGHT_SHIFT = 6'h06;
    localparam logic [5:0] FN_VAR_ARITH_RIGHT_SHIFT = 6'h07;
    localparam logic [5:0] FN_TRAPPING_SUB = 6'h22;
    localparam logic [5:0] FN_WRAPPING_DIFFERENCE = 6'h23;
    localparam logic [4:0] ISSUE_BREAK_SHAMT = 5'h01;
    // Reset values
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [4:0] DEST_RST = 5'h00;
endpackage

/* issu_rf_model.sv */
module issu_rf_model
    import issu_pkg::*;
(
    // Read side
    input wire logic clk_i,
    input wire logic valid_i,
    input wire logic [INSN_W-1:0] insn_i,
    output logic [WORD_W-1:0] operand_a_o,
    output logic [WORD_W-1:0] operand_b_o,
    // Write side
    input wire logic load_en_i,
    input wire logic [IDX_W-1:0] load_idx_i,
    input wire logic [WORD_W-1:0] load_val_i,
    input wire logic wr_en_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [WORD_W-1:0] wr_val_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] regs [32];
    wire logic [WORD_W-1:0] rd_a = (insn_i[25:21] == 5'h00) ? 32'h0 : regs[insn_i[25:21]];
    wire logic [WORD_W-1:0] rd_b = (insn_i[20:16] == 5'h00) ? 32'h0 : regs[insn_i[20:16]];
    // Idle cycles show inverted data so stale operands cannot pass by luck
    assign operand_a_o = valid_i ? rd_a : ~rd_a;
    assign operand_b_o = valid_i ? rd_b : ~rd_b;
    always_ff @(posedge clk_i) begin
        if (load_en_i) regs[load_idx_i] <= load_val_i;
        else if (wr_en_i) regs[wr_idx_i] <= wr_val_i;
    end
endmodule

/* tb.sv */
module tb
    import issu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic we; logic [4:0] d; logic [31:0] r; logic ov; logic il; logic bk;} issu_exp_t;
    logic CLK_I = 0, RST_I = 1, VALID_I = 0, DONE_O, WRITE_EN_O, OVERFLOW_O, ILLEGAL_O, ISSUE_BREAK_O, ISSUE_ALONE_O;
    logic [31:0] INSN_I = 0, OPERAND_A_I, OPERAND_B_I, RESULT_O, load_val = 0;
    logic [4:0] DEST_INDEX_O, load_idx = 0;
    logic load_en = 0;
    logic [31:0] mirror [16];
    issu_exp_t q [$];
    issu_exp_t m;
    int n_errors = 0, checked = 0;
    always #20 CLK_I = ~CLK_I;
    issu_unit issu_unit_i (.CLK_I(CLK_I), .RST_I(RST_I), .VALID_I(VALID_I), .INSN_I(INSN_I),
        .OPERAND_A_I(OPERAND_A_I), .OPERAND_B_I(OPERAND_B_I), .DONE_O(DONE_O), .WRITE_EN_O(WRITE_EN_O),
        .DEST_INDEX_O(DEST_INDEX_O), .RESULT_O(RESULT_O), .OVERFLOW_O(OVERFLOW_O), .ILLEGAL_O(ILLEGAL_O),
        .ISSUE_BREAK_O(ISSUE_BREAK_O), .ISSUE_ALONE_O(ISSUE_ALONE_O));
    issu_rf_model issu_rf_model_i (.clk_i(CLK_I), .valid_i(VALID_I), .insn_i(INSN_I), .operand_a_o(OPERAND_A_I),
        .operand_b_o(OPERAND_B_I), .load_en_i(load_en), .load_idx_i(load_idx), .load_val_i(load_val),
        .wr_en_i(WRITE_EN_O), .wr_idx_i(DEST_INDEX_O), .wr_val_i(RESULT_O));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report();
        if (n_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic issu_exp_t predict(input logic [31:0] i);
        issu_exp_t e;
        logic [31:0] a, b;
        logic [32:0] t;
        a = mirror[i[25:21]];
        b = mirror[i[20:16]];
        t = {a[31], a} - {b[31], b};
        e.bk = (i == 32'h0000_0040);
        e.ov = 0;
        e.il = (i[31:26] != 6'h00);
        e.d = i[15:11];
        e.r = 32'h0;
        case (i[5:0])
            6'h00: e.r = b << i[10:6];
            6'h02: e.r = b >> i[10:6];
            6'h06: e.r = b >> a[4:0];
            6'h07: e.r = $signed(b) >>> a[4:0];
            6'h22: begin e.r = t[31:0]; e.ov = (t[32] != t[31]); end
            6'h23: e.r = a - b;
            default: e.il = 1;
        endcase
        if (i[5:0] inside {6'h07, 6'h22, 6'h23} && i[10:6] != 5'h00) e.il = 1;
        if (e.il) e.ov = 0;
        e.we = !e.il && !e.bk && !e.ov;
        return e;
    endfunction
    task issue(input logic [31:0] i);
        @(posedge CLK_I);
        #1 VALID_I = 1;
        INSN_I = i;
        q.push_back(predict(i));
    endtask
    always @(posedge CLK_I) if (!RST_I && DONE_O === 1'b1) begin
        if (q.size() == 0) check(1, 0);
        else begin
            m = q.pop_front();
            check(WRITE_EN_O, m.we);
            if (m.we) check(RESULT_O, m.r);
            if (m.we) check(DEST_INDEX_O, m.d);
            check(OVERFLOW_O, m.ov);
            check(ILLEGAL_O, m.il);
            check(ISSUE_BREAK_O, m.bk);
            check(ISSUE_ALONE_O, m.bk);
        end
    end
    initial begin
        #200us n_errors++;
        final_report();
    end
    initial begin
        logic [5:0] tbl [6] = '{6'h00, 6'h02, 6'h06, 6'h07, 6'h22, 6'h23};
        logic [5:0] f;
        void'($urandom(32'hd671bfba));
        repeat (3) @(posedge CLK_I);
        for (int k = 0; k < 16; k++) begin
            @(posedge CLK_I);
            #1 load_en = 1;
            load_idx = k;
            // Edge operands for overflow and for counts with high bits set
            case (k)
                0: load_val = 0;
                1: load_val = 32'h8000_0000;
                2: load_val = 32'h1;
                3: load_val = 32'h7fff_ffff;
                4: load_val = 32'hffff_ffff;
                5: load_val = 32'hffff_ffe5;
                default: load_val = $urandom;
            endcase
            mirror[k] = load_val;
        end
        @(posedge CLK_I);
        #1 load_en = 0;
        RST_I = 0;
        issue(32'h0022_0022);
        issue(32'h0064_0022);
        issue(32'h0022_8023);
        issue(32'h0022_8062);
        issue(32'h0400_0000);
        issue(32'h0000_003f);
        issue(32'h0000_0040);
        issue(32'h0000_0040);
        issue(32'h0000_0000);
        for (int n = 0; n < 400; n++) begin
            f = tbl[$urandom_range(0, 5)];
            if ($urandom_range(0, 9) == 0) issue(32'h0000_0040);
            else issue({6'h00, 5'($urandom_range(0, 15)), 5'($urandom_range(0, 15)), 5'($urandom_range(16, 31)),
                (f == 6'h00 || f == 6'h02) ? 5'($urandom) : 5'h00, f});
        end
        @(posedge CLK_I);
        #1 VALID_I = 0;
        repeat (3) @(posedge CLK_I);
        check(q.size(), 0);
        final_report();
    end
endmodule
